// ==== hw/sktc_pkg.sv ====
/*
 * Shared constants of the seek and temperature-sense command block.
 * Assumes an AXI4-Lite master with 32-bit data, and one clock and one reset.
 */
// Function
// - Any command code 7xh is a seek; low nibble ignored; seek track, select head.
// - Seek runs on unformatted media and is never refused for that.
// - In block mode, sector number carries address bits 0 to 7.
// - Cylinder registers carry cylinder, or address bits 8-15 low, 16-23 high.
// - Head bits carry head number, or address bits 24 to 27.
// - After a block-mode seek the current address returns in the same fields.
// - Command F0h senses device temperature and reports the result.
// - Temperature sense runs even while held in power-up-in-standby.
// - Temperature sense needs feature 01h; any other value aborts the command.
// - The encoded temperature lands in the sector count register.
// - Code 00h is -20 or colder, 01h-FEh is code/2-20, FFh above 107.
package sktc_pkg;

   // Register byte offsets.
   localparam logic [5:0] SKTC_OFS_FEATURE = 6'h00;
   localparam logic [5:0] SKTC_OFS_SECT_COUNT = 6'h04;
   localparam logic [5:0] SKTC_OFS_SECT_NUMBER = 6'h08;
   localparam logic [5:0] SKTC_OFS_CYL_LOW = 6'h0C;
   localparam logic [5:0] SKTC_OFS_CYL_HIGH = 6'h10;
   localparam logic [5:0] SKTC_OFS_DRIVE_HEAD = 6'h14;
   localparam logic [5:0] SKTC_OFS_COMMAND = 6'h18;
   localparam logic [5:0] SKTC_OFS_ERROR = 6'h1C;
   localparam logic [5:0] SKTC_OFS_STATUS = 6'h20;
   localparam logic [5:0] SKTC_OFS_IRQ_STATUS = 6'h24;
   localparam logic [5:0] SKTC_OFS_IRQ_CLEAR = 6'h28;
   localparam logic [5:0] SKTC_OFS_IRQ_ENABLE = 6'h2C;

   // Field positions.
   localparam int SKTC_DH_LBA_BIT = 6;
   localparam int SKTC_ST_BUSY = 7;
   localparam int SKTC_ST_READY = 6;
   localparam int SKTC_ST_FAULT = 5;
   localparam int SKTC_ST_SEEK_DONE = 4;
   localparam int SKTC_ST_XFER_REQ = 3;
   localparam int SKTC_ST_CORRECTED = 2;
   localparam int SKTC_ST_ERROR = 0;
   localparam int SKTC_ER_ID_NOT_FOUND = 4;
   localparam int SKTC_ER_ABORT = 2;
   localparam int SKTC_IRQ_DONE = 0;
   localparam int SKTC_IRQ_FAIL = 1;
   localparam int SKTC_IRQ_W = 2;

   // Command codes and values.
   localparam logic [3:0] SKTC_CMD_SEEK_NIBBLE = 4'h7;
   localparam logic [7:0] SKTC_CMD_TEMP_SENSE = 8'hF0;
   localparam logic [7:0] SKTC_TEMP_FEATURE = 8'h01;

   // Reset values.
   localparam logic [7:0] SKTC_STATUS_RESET = 8'h50;
   localparam logic [7:0] SKTC_ERROR_RESET = 8'h00;

   // Temperature coding in half degrees: offset of -20 degrees, top code.
   localparam int SKTC_TEMP_OFFSET_HALF = 40;
   localparam int SKTC_TEMP_TOP_CODE = 254;

   localparam logic [1:0] SKTC_RESP_OKAY = 2'h0;
   localparam logic [1:0] SKTC_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SKTC_ST_IDLE = 3'b001,
      SKTC_ST_SEEKING = 3'b010,
      SKTC_ST_SENSING = 3'b100
   } sktc_state_t;

endpackage

// ==== hw/sktc_temp_code.sv ====
/*
 * Encoder from a signed reading in half degrees to the one-byte result code.
 * Assumes the reading is valid in the cycle its strobe is high.
 */
`timescale 1ns/1ps
module sktc_temp_code
   import sktc_pkg::*;
#(
   parameter int TEMP_W = 10
) (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // Reading.
   input wire logic i_valid,
   input wire logic signed [TEMP_W-1:0] i_temp_half,
   // Result.
   output logic o_valid,
   output logic [7:0] o_code
);
   import sktc_pkg::*;

   // The 18-bit sum below only serves readings of 9 to 16 bits.
   if (TEMP_W < 9 || TEMP_W > 16) begin : gen_width_check
      $error("sktc_temp_code: TEMP_W out of range");
   end

   logic signed [17:0] shifted;
   logic [7:0] next_code;

   assign shifted = 18'(i_temp_half) + 18'(SKTC_TEMP_OFFSET_HALF);

   // Saturate both ends so no reading wraps into a plausible code.
   always_comb begin
      if (shifted <= 18'sd0) begin
         next_code = 8'h00;
      end else if (shifted > 18'(SKTC_TEMP_TOP_CODE)) begin
         next_code = 8'hFF;
      end else begin
         next_code = shifted[7:0];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_code <= 8'h00;
         o_valid <= 1'b0;
      end else begin
         o_valid <= i_valid;
         if (i_valid) begin
            o_code <= next_code;
         end
      end
   end

endmodule // sktc_temp_code

// ==== hw/sktc_cmd_top.sv ====
/*
 * Task-file registers and command execution for seek and temperature sense.
 * Assumes an AXI4-Lite master, a positioner and sensor on the same clock,
 * and a standby level from outside the clock domain.
 */
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module sktc_cmd_top
   import sktc_pkg::*;
#(
   parameter int TEMP_W = 10
) (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // AXI4-Lite write address and data.
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [5:0] i_awaddr,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   // AXI4-Lite write response.
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   // AXI4-Lite read.
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [5:0] i_araddr,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   // Positioner.
   output logic o_seek_req,
   output logic o_seek_lba,
   output logic [27:0] o_seek_addr,
   input wire logic i_seek_done,
   input wire logic i_seek_fail,
   input wire logic i_seek_id_missing,
   input wire logic [27:0] i_seek_pos,
   // Temperature sensor.
   output logic o_temp_req,
   input wire logic i_temp_valid,
   input wire logic signed [TEMP_W-1:0] i_temp_half,
   // Power state and interrupt.
   input wire logic i_standby,
   output logic o_irq
);
   import sktc_pkg::*;

   logic [7:0] feature, sect_count, sect_number, cyl_low, cyl_high, drive_head;
   logic [7:0] error_flags, completion_flags;
   logic [SKTC_IRQ_W-1:0] irq_status, irq_enable;
   logic aw_held, w_held;
   logic [5:0] aw_addr;
   logic [7:0] w_byte;
   logic w_lane;
   logic wr_fire, rd_fire;
   logic standby_meta, standby;
   sktc_state_t state;
   logic cmd_write, busy;
   logic done_ok, done_fail, abort_now, idnf_now;
   logic code_valid;
   logic [7:0] code;
   logic [7:0] rd_byte;
   logic rd_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave.

   assign o_awready = !aw_held && !o_bvalid;
   assign o_wready = !w_held && !o_bvalid;
   assign wr_fire = aw_held && w_held && !o_bvalid;
   assign o_arready = !o_rvalid;
   assign rd_fire = i_arvalid && !o_rvalid;

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         aw_held <= 1'b0;
         aw_addr <= 6'h00;
      end else if (i_awvalid && o_awready) begin
         aw_held <= 1'b1;
         aw_addr <= {i_awaddr[5:2], 2'b00};
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         w_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
      end else if (i_wvalid && o_wready) begin
         w_held <= 1'b1;
         w_byte <= i_wdata[7:0];
         w_lane <= i_wstrb[0];
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_bvalid <= 1'b0;
         o_bresp <= SKTC_RESP_OKAY;
      end else if (wr_fire) begin
         o_bvalid <= 1'b1;
         o_bresp <= (aw_addr <= SKTC_OFS_COMMAND || aw_addr == SKTC_OFS_IRQ_CLEAR
                     || aw_addr == SKTC_OFS_IRQ_ENABLE) ? SKTC_RESP_OKAY : SKTC_RESP_SLVERR;
      end else if (i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   always_comb begin
      rd_hit = 1'b1;
      case (i_araddr[5:2])
         SKTC_OFS_FEATURE[5:2]: rd_byte = feature;
         SKTC_OFS_SECT_COUNT[5:2]: rd_byte = sect_count;
         SKTC_OFS_SECT_NUMBER[5:2]: rd_byte = sect_number;
         SKTC_OFS_CYL_LOW[5:2]: rd_byte = cyl_low;
         SKTC_OFS_CYL_HIGH[5:2]: rd_byte = cyl_high;
         SKTC_OFS_DRIVE_HEAD[5:2]: rd_byte = drive_head;
         SKTC_OFS_ERROR[5:2]: rd_byte = error_flags;
         SKTC_OFS_STATUS[5:2]: rd_byte = completion_flags;
         SKTC_OFS_IRQ_STATUS[5:2]: rd_byte = {6'h00, irq_status};
         SKTC_OFS_IRQ_ENABLE[5:2]: rd_byte = {6'h00, irq_enable};
         SKTC_OFS_COMMAND[5:2], SKTC_OFS_IRQ_CLEAR[5:2]: rd_byte = 8'h00;
         default: begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= SKTC_RESP_OKAY;
      end else if (rd_fire) begin
         o_rvalid <= 1'b1;
         o_rdata <= {24'h000000, rd_byte};
         o_rresp <= rd_hit ? SKTC_RESP_OKAY : SKTC_RESP_SLVERR;
      end else if (i_rready) begin
         o_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Standby level synchroniser.

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         standby_meta <= 1'b0;
         standby <= 1'b0;
      end else begin
         standby_meta <= i_standby;
         standby <= standby_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command decode and sequencing.

   assign busy = completion_flags[SKTC_ST_BUSY];
   assign cmd_write = wr_fire && w_lane && aw_addr == SKTC_OFS_COMMAND && !busy;
   assign done_ok = (state == SKTC_ST_SEEKING && i_seek_done && !i_seek_fail)
                    || (state == SKTC_ST_SENSING && code_valid);
   assign done_fail = (state == SKTC_ST_SEEKING && i_seek_fail) || abort_now;
   assign idnf_now = state == SKTC_ST_SEEKING && i_seek_fail && i_seek_id_missing;

   // A seek needs the spindle, so it is refused in standby; sensing is not. The
   // media format is never consulted before a seek.
   always_comb begin
      abort_now = 1'b0;
      if (cmd_write) begin
         if (w_byte[7:4] == SKTC_CMD_SEEK_NIBBLE) begin
            abort_now = standby;
         end else if (w_byte == SKTC_CMD_TEMP_SENSE) begin
            abort_now = feature != SKTC_TEMP_FEATURE;
         end else begin
            abort_now = 1'b1;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= SKTC_ST_IDLE;
      end else begin
         case (state)
            SKTC_ST_IDLE: begin
               if (cmd_write && !abort_now) begin
                  state <= (w_byte == SKTC_CMD_TEMP_SENSE) ? SKTC_ST_SENSING
                           : SKTC_ST_SEEKING;
               end
            end
            SKTC_ST_SEEKING: begin
               if (i_seek_done || i_seek_fail) begin
                  state <= SKTC_ST_IDLE;
               end
            end
            SKTC_ST_SENSING: begin
               if (code_valid) begin
                  state <= SKTC_ST_IDLE;
               end
            end
            default: state <= SKTC_ST_IDLE;
         endcase
      end
   end

   // Requests are one-cycle strobes issued as the command is accepted.
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_seek_req <= 1'b0;
         o_temp_req <= 1'b0;
         o_seek_lba <= 1'b0;
         o_seek_addr <= 28'h0000000;
      end else begin
         o_seek_req <= cmd_write && !abort_now && w_byte[7:4] == SKTC_CMD_SEEK_NIBBLE;
         o_temp_req <= cmd_write && !abort_now && w_byte == SKTC_CMD_TEMP_SENSE;
         if (cmd_write) begin
            o_seek_lba <= drive_head[SKTC_DH_LBA_BIT];
            o_seek_addr <= drive_head[SKTC_DH_LBA_BIT]
               ? {drive_head[3:0], cyl_high, cyl_low, sect_number}
               : {drive_head[3:0], 8'h00, cyl_high, cyl_low};
         end
      end
   end

   sktc_temp_code #(
      .TEMP_W(TEMP_W)
   ) u_temp_code (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_valid(i_temp_valid && state == SKTC_ST_SENSING),
      .i_temp_half(i_temp_half),
      .o_valid(code_valid),
      .o_code(code)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Task file; host writes are held off while a command runs.

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         feature <= 8'h00;
         sect_count <= 8'h00;
         sect_number <= 8'h00;
         cyl_low <= 8'h00;
         cyl_high <= 8'h00;
         drive_head <= 8'h00;
      end else begin
         if (wr_fire && w_lane && !busy) begin
            case (aw_addr)
               SKTC_OFS_FEATURE: feature <= w_byte;
               SKTC_OFS_SECT_COUNT: sect_count <= w_byte;
               SKTC_OFS_SECT_NUMBER: sect_number <= w_byte;
               SKTC_OFS_CYL_LOW: cyl_low <= w_byte;
               SKTC_OFS_CYL_HIGH: cyl_high <= w_byte;
               SKTC_OFS_DRIVE_HEAD: drive_head <= w_byte;
               default: ;
            endcase
         end
         if (state == SKTC_ST_SENSING && code_valid) begin
            sect_count <= code;
         end
         if (done_ok && state == SKTC_ST_SEEKING && o_seek_lba) begin
            sect_number <= i_seek_pos[7:0];
            cyl_low <= i_seek_pos[15:8];
            cyl_high <= i_seek_pos[23:16];
            drive_head[3:0] <= i_seek_pos[27:24];
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         completion_flags <= SKTC_STATUS_RESET;
         error_flags <= SKTC_ERROR_RESET;
      end else if (done_fail) begin
         completion_flags[SKTC_ST_BUSY] <= 1'b0;
         completion_flags[SKTC_ST_FAULT] <= 1'b0;
         completion_flags[SKTC_ST_CORRECTED] <= 1'b0;
         completion_flags[SKTC_ST_READY] <= 1'b1;
         completion_flags[SKTC_ST_XFER_REQ] <= 1'b0;
         completion_flags[SKTC_ST_ERROR] <= 1'b1;
         error_flags <= 8'h00;
         error_flags[SKTC_ER_ID_NOT_FOUND] <= idnf_now;
         error_flags[SKTC_ER_ABORT] <= !idnf_now;
      end else if (done_ok) begin
         completion_flags[SKTC_ST_BUSY] <= 1'b0;
         completion_flags[SKTC_ST_FAULT] <= 1'b0;
         completion_flags[SKTC_ST_CORRECTED] <= 1'b0;
         completion_flags[SKTC_ST_READY] <= 1'b1;
         completion_flags[SKTC_ST_ERROR] <= 1'b0;
         if (state == SKTC_ST_SEEKING) begin
            completion_flags[SKTC_ST_SEEK_DONE] <= 1'b1;
         end
         error_flags <= 8'h00;
      end else if (cmd_write) begin
         completion_flags[SKTC_ST_BUSY] <= 1'b1;
         completion_flags[SKTC_ST_READY] <= 1'b0;
         completion_flags[SKTC_ST_ERROR] <= 1'b0;
         if (w_byte[7:4] == SKTC_CMD_SEEK_NIBBLE) begin
            completion_flags[SKTC_ST_SEEK_DONE] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts; a completion in the clearing cycle stays set.

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_enable <= '0;
      end else if (wr_fire && w_lane && aw_addr == SKTC_OFS_IRQ_ENABLE) begin
         irq_enable <= w_byte[SKTC_IRQ_W-1:0];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_status <= '0;
      end else begin
         for (int i = 0; i < SKTC_IRQ_W; i++) begin
            if ((i == SKTC_IRQ_DONE && done_ok) || (i == SKTC_IRQ_FAIL && done_fail)) begin
               irq_status[i] <= 1'b1;
            end else if (wr_fire && w_lane && aw_addr == SKTC_OFS_IRQ_CLEAR && w_byte[i]) begin
               irq_status[i] <= 1'b0;
            end
         end
      end
   end

   assign o_irq = |(irq_status & irq_enable);

endmodule // sktc_cmd_top

// ==== dv/sktc_far_model.sv ====
/*
 * Positioner and temperature sensor model for the command block.
 * Assumes the block's clock, and that the bench sets the wait, fail and reading inputs.
 */
`timescale 1ns/1ps
module sktc_far_model
   import sktc_pkg::*;
#(
   parameter int TEMP_W = 10
) (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // Requests from the block.
   input wire logic i_seek_req,
   input wire logic [27:0] i_seek_addr,
   input wire logic i_temp_req,
   // Bench controls.
   input wire logic [3:0] i_wait,
   input wire logic i_fail,
   input wire logic i_id_miss,
   input wire logic signed [TEMP_W-1:0] i_temp,
   // Answers.
   output logic o_seek_done,
   output logic o_seek_fail,
   output logic o_seek_id_missing,
   output logic [27:0] o_seek_pos,
   output logic o_temp_valid,
   output logic signed [TEMP_W-1:0] o_temp_half
);
   logic [3:0] cnt;
   logic sk;
   logic tp;
   logic [27:0] pos;
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt <= 4'h0; sk <= 1'b0; tp <= 1'b0; pos <= 28'h0;
         o_seek_done <= 1'b0; o_seek_fail <= 1'b0; o_temp_valid <= 1'b0;
      end else begin
         o_seek_done <= 1'b0; o_seek_fail <= 1'b0; o_temp_valid <= 1'b0;
         if (i_seek_req || i_temp_req) begin
            cnt <= i_wait; sk <= i_seek_req; tp <= i_temp_req;
            pos <= i_seek_addr + 28'h1;
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else if (sk || tp) begin
            sk <= 1'b0; tp <= 1'b0;
            o_seek_done <= sk && !i_fail;
            o_seek_fail <= sk && i_fail;
            o_temp_valid <= tp;
         end
      end
   end
   // Outside an answer the lines show inverted values, so a stale sample cannot match.
   assign o_seek_id_missing = o_seek_fail ? i_id_miss : !i_id_miss;
   assign o_seek_pos = o_seek_done ? pos : ~pos;
   assign o_temp_half = o_temp_valid ? i_temp : ~i_temp;
endmodule // sktc_far_model

// ==== dv/sktc_cmd_monitor.sv ====
/*
 * Concurrent checks on the command block's ports.
 * Assumes it is bound to every instance of the top module.
 */
`timescale 1ns/1ps
module sktc_cmd_monitor
   import sktc_pkg::*;
(
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // Register bus.
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic [5:0] i_awaddr,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic [1:0] o_bresp,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic [31:0] o_rdata,
   // Requests.
   input wire logic o_seek_req,
   input wire logic o_temp_req
);
   logic [5:0] aw_q;
   logic [7:0] wd_q;
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         aw_q <= 6'h00; wd_q <= 8'h00;
      end else begin
         if (i_awvalid && o_awready) aw_q <= i_awaddr;
         if (i_wvalid && o_wready) wd_q <= i_wdata[7:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   AST_SEEK_CMD: assert property (o_seek_req |-> $rose(o_bvalid) &&
      aw_q == SKTC_OFS_COMMAND && wd_q[7:4] == SKTC_CMD_SEEK_NIBBLE) else $error("bad seek start");
   AST_TEMP_CMD: assert property (o_temp_req |-> $rose(o_bvalid) &&
      aw_q == SKTC_OFS_COMMAND && wd_q == SKTC_CMD_TEMP_SENSE) else $error("bad sense start");
   AST_REQ_EXCL: assert property (o_seek_req |-> !o_temp_req ##1 !o_seek_req)
      else $error("seek request not a lone pulse");
   AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped");
   AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped");
   AST_R_LAT: assert property (i_arvalid && o_arready |=> o_rvalid) else $error("read late");
   AST_R_UPPER: assert property (o_rvalid |-> o_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   AST_B_BLOCK: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write taken during response");
endmodule // sktc_cmd_monitor
bind sktc_cmd_top sktc_cmd_monitor mon_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
   .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
   .o_wready(o_wready), .i_wdata(i_wdata), .o_bvalid(o_bvalid), .i_bready(i_bready),
   .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
   .i_rready(i_rready), .o_rdata(o_rdata), .o_seek_req(o_seek_req), .o_temp_req(o_temp_req));

// ==== dv/tb.sv ====
/*
 * Self-checking bench: register tasks on the bus, seek and sense sequences.
 * Assumes the far model answers within its programmed wait.
 */
`timescale 1ns/1ps
module tb;
   import sktc_pkg::*;
   logic clk = 0, nrst = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, sby = 0;
   logic [5:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd_d;
   logic awr, wr_r, bv, arr, rv, sreq, slba, sdone, sfail, sidm, treq, tv, irq, fl = 0, idm = 0;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata;
   logic [27:0] saddr, spos, cap = 0;
   logic [3:0] wt = 4'h3;
   logic signed [9:0] tin = 0, thalf;
   int fail_count = 0, cmp_count = 0;
   int i;
   logic signed [9:0] tl [6] = '{-41, -40, -39, 0, 214, 215};
   logic [7:0] te [6] = '{8'h00, 8'h00, 8'h01, 8'h28, 8'hFE, 8'hFF};
   sktc_cmd_top #(.TEMP_W(10)) dut_u (.i_ref_clk(clk), .i_nrst(nrst), .i_awvalid(awv),
      .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wr_r), .i_wdata(wd),
      .i_wstrb(4'hF), .o_bvalid(bv), .i_bready(br), .o_bresp(bresp), .i_arvalid(arv),
      .o_arready(arr), .i_araddr(ara), .o_rvalid(rv), .i_rready(rr), .o_rdata(rdata),
      .o_rresp(rresp), .o_seek_req(sreq), .o_seek_lba(slba), .o_seek_addr(saddr),
      .i_seek_done(sdone), .i_seek_fail(sfail), .i_seek_id_missing(sidm), .i_seek_pos(spos),
      .o_temp_req(treq), .i_temp_valid(tv), .i_temp_half(thalf), .i_standby(sby), .o_irq(irq));
   sktc_far_model #(.TEMP_W(10)) far_u (.i_ref_clk(clk), .i_nrst(nrst), .i_seek_req(sreq),
      .i_seek_addr(saddr), .i_temp_req(treq), .i_wait(wt), .i_fail(fl), .i_id_miss(idm),
      .i_temp(tin), .o_seek_done(sdone), .o_seek_fail(sfail), .o_seek_id_missing(sidm),
      .o_seek_pos(spos), .o_temp_valid(tv), .o_temp_half(thalf));
   initial forever #25 clk = ~clk;
   always @(posedge clk) if (sreq === 1'b1) cap <= saddr;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   // Ready is sampled mid-cycle; inputs only move at rising edges, so it holds to the edge.
   task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ta, tw, ha, hw;
      ha = 0; hw = 0;
      @(posedge clk); awa <= a; wd <= {24'h0, d}; awv <= 1; wv <= 1; br <= 1;
      while (!(ha && hw)) begin
         @(negedge clk); ta = !ha && awr; tw = !hw && wr_r;
         @(posedge clk); if (ta) begin awv <= 0; ha = 1; end
         if (tw) begin wv <= 0; hw = 1; end
      end
      do @(negedge clk); while (bv !== 1'b1);
      resp = bresp;
      @(posedge clk); br <= 0;
      chk({30'h0, resp}, {30'h0, er});
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge clk); ara <= a; arv <= 1; rr <= 1;
      do @(negedge clk); while (arr !== 1'b1);
      @(posedge clk); arv <= 0;
      do @(negedge clk); while (rv !== 1'b1);
      rd_d = rdata; resp = rresp;
      @(posedge clk); rr <= 0;
      chk(rd_d, {24'h0, e}); chk({30'h0, resp}, {30'h0, er});
   endtask
   task automatic idle();
      repeat (20) @(posedge clk);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      results();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1;
      rd(SKTC_OFS_STATUS, SKTC_STATUS_RESET, SKTC_RESP_OKAY);
      rd(SKTC_OFS_ERROR, SKTC_ERROR_RESET, SKTC_RESP_OKAY);
      rd(6'h30, 8'h00, SKTC_RESP_SLVERR);
      wr(6'h34, 8'h55, SKTC_RESP_SLVERR);
      wr(SKTC_OFS_IRQ_ENABLE, 8'h03, SKTC_RESP_OKAY);
      wr(SKTC_OFS_SECT_NUMBER, 8'h12, SKTC_RESP_OKAY);
      wr(SKTC_OFS_CYL_LOW, 8'h34, SKTC_RESP_OKAY);
      wr(SKTC_OFS_CYL_HIGH, 8'h56, SKTC_RESP_OKAY);
      wr(SKTC_OFS_DRIVE_HEAD, 8'h47, SKTC_RESP_OKAY);
      wr(SKTC_OFS_COMMAND, 8'h7A, SKTC_RESP_OKAY);
      rd(SKTC_OFS_STATUS, 8'h80, SKTC_RESP_OKAY);
      idle();
      chk({4'h0, cap}, 32'h07563412);
      chk({31'h0, slba}, 32'h1);
      rd(SKTC_OFS_STATUS, 8'h50, SKTC_RESP_OKAY);
      rd(SKTC_OFS_ERROR, 8'h00, SKTC_RESP_OKAY);
      rd(SKTC_OFS_SECT_NUMBER, 8'h13, SKTC_RESP_OKAY);
      rd(SKTC_OFS_CYL_LOW, 8'h34, SKTC_RESP_OKAY);
      rd(SKTC_OFS_CYL_HIGH, 8'h56, SKTC_RESP_OKAY);
      rd(SKTC_OFS_IRQ_STATUS, 8'h01, SKTC_RESP_OKAY);
      chk({31'h0, irq}, 32'h1);
      wr(SKTC_OFS_IRQ_CLEAR, 8'h01, SKTC_RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      wr(SKTC_OFS_IRQ_ENABLE, 8'h00, SKTC_RESP_OKAY);
      wr(SKTC_OFS_DRIVE_HEAD, 8'h03, SKTC_RESP_OKAY);
      for (i = 0; i < 2; i++) begin
         fl <= i[0]; idm <= i[0];
         wr(SKTC_OFS_COMMAND, i[0] ? 8'h7F : 8'h70, SKTC_RESP_OKAY);
         idle();
         chk({4'h0, cap}, 32'h03005634);
         chk({31'h0, slba}, 32'h0);
         rd(SKTC_OFS_STATUS, i[0] ? 8'h41 : 8'h50, SKTC_RESP_OKAY);
         rd(SKTC_OFS_ERROR, i[0] ? 8'h10 : 8'h00, SKTC_RESP_OKAY);
      end
      idm <= 0;
      wr(SKTC_OFS_COMMAND, 8'h75, SKTC_RESP_OKAY);
      idle();
      rd(SKTC_OFS_ERROR, 8'h04, SKTC_RESP_OKAY);
      rd(SKTC_OFS_IRQ_STATUS, 8'h03, SKTC_RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      fl <= 0;
      wr(SKTC_OFS_FEATURE, 8'h02, SKTC_RESP_OKAY);
      wr(SKTC_OFS_COMMAND, SKTC_CMD_TEMP_SENSE, SKTC_RESP_OKAY);
      rd(SKTC_OFS_ERROR, 8'h04, SKTC_RESP_OKAY);
      rd(SKTC_OFS_STATUS, 8'h41, SKTC_RESP_OKAY);
      wr(SKTC_OFS_FEATURE, SKTC_TEMP_FEATURE, SKTC_RESP_OKAY);
      for (i = 0; i < 6; i++) begin
         tin <= tl[i]; sby <= i[0];
         wr(SKTC_OFS_COMMAND, SKTC_CMD_TEMP_SENSE, SKTC_RESP_OKAY);
         idle();
         rd(SKTC_OFS_SECT_COUNT, te[i], SKTC_RESP_OKAY);
         rd(SKTC_OFS_ERROR, 8'h00, SKTC_RESP_OKAY);
      end
      wr(SKTC_OFS_COMMAND, 8'h70, SKTC_RESP_OKAY);
      rd(SKTC_OFS_ERROR, 8'h04, SKTC_RESP_OKAY);
      results();
   end
endmodule // tb
